// ### rtl/cssc_pkg.sv
package cssc_pkg;
  localparam int unsigned CLK_MHZ       = 100;
  localparam int unsigned SLOW_US       = 150;
  localparam int unsigned FAST_US       = 2;
  localparam int unsigned SLOW_CYC      = SLOW_US * CLK_MHZ;
  localparam int unsigned FAST_CYC      = FAST_US * CLK_MHZ;
  localparam int unsigned CNT_W         = 15;
  localparam logic [1:0] ADDR_CORE_CTL  = 2'h0;
  localparam logic [1:0] ADDR_SUP_CTL   = 2'h1;
  localparam logic [1:0] ADDR_STATUS    = 2'h2;
  // Control bits shared by core and supply control; B_OVP is used in supply control only
  localparam int unsigned B_SVE   = 0;
  localparam int unsigned B_SVLP  = 1;
  localparam int unsigned B_SVFP  = 2;
  localparam int unsigned B_MNE   = 3;
  localparam int unsigned B_MNFP  = 4;
  localparam int unsigned B_AUTO  = 5;
  localparam int unsigned B_OVP   = 6;
  localparam logic [15:0] CORE_CTL_RST = 16'h0009;
  localparam logic [15:0] SUP_CTL_RST  = 16'h0000;

  typedef enum logic [1:0] {
    CSSC_OFF    = 2'h0,
    CSSC_NORMAL = 2'h1,
    CSSC_FULL   = 2'h3
  } cssc_state_e;

  typedef enum logic [1:0] {
    PM_ACTIVE = 2'h0,
    PM_LIGHT  = 2'h1,
    PM_DEEP   = 2'h3
  } cssc_pmode_e;

  typedef struct packed {
    logic        write;
    logic        read;
    logic [1:0]  addr;
    logic [15:0] wdata;
  } cssc_bus_s;

  typedef struct packed {
    cssc_state_e coreSup;
    cssc_state_e coreMon;
    cssc_state_e supSup;
    cssc_state_e supMon;
  } cssc_chan_s;
endpackage

// ### rtl/cssc_mode_control.sv
`timescale 1ns/100ps
`default_nettype none
module cssc_mode_control
  import cssc_pkg::*;
#(
  parameter int unsigned SLOW_CYCLES = SLOW_CYC,
  parameter int unsigned FAST_CYCLES = FAST_CYC
) (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire cssc_bus_s   bus,
  output logic      [15:0] rdata,
  input  wire logic        lowPowerMode2,
  input  wire logic        lowPowerMode34,
  input  wire logic        wakeUp,
  input  wire logic        coreVoltageLow,
  input  wire logic        supplyOverVoltage,
  output cssc_chan_s       chanState,
  output logic             cpuExecMask,
  output logic             coreSideSettleFlag,
  output logic             supplySideSettleFlag,
  output logic             powerUpClear
);
  logic [1:0] pinLp2Q, pinLp34Q, pinWakeQ, pinLowQ, pinOvQ;
  logic [15:0] coreCtl_q, coreCtl_d, supCtl_q, supCtl_d;
  cssc_pmode_e pmode_q, pmode_d;
  cssc_chan_s chan_q, chan_d;
  logic [CNT_W-1:0] coreCnt_q, coreCnt_d, supCnt_q, supCnt_d, maskCnt_q, maskCnt_d;
  logic coreFlag_q, coreFlag_d, supFlag_q, supFlag_d, mask_q, mask_d;
  logic puc_q, puc_d;
  logic [15:0] rdata_q, rdata_d;

  // Two-stage synchronisers for pin inputs
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pinLp2Q  <= 2'h0;
      pinLp34Q <= 2'h0;
      pinWakeQ <= 2'h0;
      pinLowQ  <= 2'h0;
      pinOvQ   <= 2'h0;
    end else begin
      pinLp2Q  <= {pinLp2Q[0], lowPowerMode2};
      pinLp34Q <= {pinLp34Q[0], lowPowerMode34};
      pinWakeQ <= {pinWakeQ[0], wakeUp};
      pinLowQ  <= {pinLowQ[0], coreVoltageLow};
      pinOvQ   <= {pinOvQ[0], supplyOverVoltage};
    end
  end

  function automatic cssc_state_e supMap(input logic en, input logic lp, input logic fp,
                                         input logic auto, input cssc_pmode_e pm);
    cssc_state_e act;
    act = fp ? CSSC_FULL : CSSC_NORMAL;
    if (!en) begin
      supMap = CSSC_OFF;
    end else if (pm != PM_DEEP) begin
      supMap = act;
    end else if (!lp) begin
      supMap = CSSC_OFF;
    end else if (!auto) begin
      supMap = act;
    end else begin
      supMap = fp ? CSSC_NORMAL : CSSC_OFF;
    end
  endfunction

  // Monitor is the supervisor map with low-power bit forced on
  function automatic cssc_state_e monMap(input logic en, input logic fp,
                                         input logic auto, input cssc_pmode_e pm);
    monMap = supMap(en, 1'b1, fp, auto, pm);
  endfunction

  logic coreWr, supWr, deepWake, fastWake, pmChange;
  cssc_pmode_e pmNow;
  logic [15:0] wdNext;

  always_comb begin
    coreWr   = bus.write && (bus.addr == ADDR_CORE_CTL);
    supWr    = bus.write && (bus.addr == ADDR_SUP_CTL);
    pmNow    = pinLp34Q[1] ? PM_DEEP : (pinLp2Q[1] ? PM_DEEP : PM_ACTIVE);
    pmChange = (pmNow != pmode_q);
    deepWake = (pmode_q == PM_DEEP) && (pmNow != PM_DEEP);
    wdNext   = bus.wdata;
    coreCtl_d = coreWr ? wdNext : coreCtl_q;
    supCtl_d  = supWr ? wdNext : supCtl_q;
    pmode_d   = pmNow;
    chan_d = chan_q;
    if (pmChange || coreWr || supWr) begin
      chan_d.coreSup = supMap(coreCtl_d[B_SVE], coreCtl_d[B_SVLP], coreCtl_d[B_SVFP],
                              coreCtl_d[B_AUTO], pmNow);
      chan_d.coreMon = monMap(coreCtl_d[B_MNE], coreCtl_d[B_MNFP], coreCtl_d[B_AUTO], pmNow);
      chan_d.supSup  = supMap(supCtl_d[B_SVE], supCtl_d[B_SVLP], supCtl_d[B_SVFP],
                              supCtl_d[B_AUTO], pmNow);
      chan_d.supMon  = monMap(supCtl_d[B_MNE], supCtl_d[B_MNFP], supCtl_d[B_AUTO], pmNow);
    end
    // Slow wake-up if either core comparator runs normal
    fastWake = !((coreCtl_q[B_SVE] && !coreCtl_q[B_SVFP]) ||
                 (coreCtl_q[B_MNE] && !coreCtl_q[B_MNFP]));
    mask_d    = mask_q;
    maskCnt_d = maskCnt_q;
    if (deepWake) begin
      mask_d    = 1'b1;
      maskCnt_d = fastWake ? CNT_W'(FAST_CYCLES - 1) : CNT_W'(SLOW_CYCLES - 1);
    end else if (mask_q) begin
      if (maskCnt_q == '0) begin
        mask_d = 1'b0;
      end else begin
        maskCnt_d = maskCnt_q - 1'b1;
      end
    end
    coreFlag_d = coreFlag_q;
    coreCnt_d  = coreCnt_q;
    if (coreWr) begin
      coreFlag_d = 1'b1;
      coreCnt_d  = wdNext[B_SVFP] ? CNT_W'(FAST_CYCLES - 1) : CNT_W'(SLOW_CYCLES - 1);
    end else if (coreFlag_q) begin
      if (coreCnt_q == '0) begin
        coreFlag_d = 1'b0;
      end else begin
        coreCnt_d = coreCnt_q - 1'b1;
      end
    end
    supFlag_d = supFlag_q;
    supCnt_d  = supCnt_q;
    if (supWr) begin
      supFlag_d = 1'b1;
      supCnt_d  = wdNext[B_SVFP] ? CNT_W'(FAST_CYCLES - 1) : CNT_W'(SLOW_CYCLES - 1);
    end else if (supFlag_q) begin
      if (supCnt_q == '0) begin
        supFlag_d = 1'b0;
      end else begin
        supCnt_d = supCnt_q - 1'b1;
      end
    end
    puc_d = (coreFlag_q && !coreWr && coreCnt_q == '0 && pinLowQ[1] && coreCtl_q[B_SVE])
         || (supCtl_q[B_OVP] && supCtl_q[B_MNE] && pinOvQ[1]);
    rdata_d = 16'h0000;
    if (bus.read) begin
      unique case (bus.addr)
        ADDR_CORE_CTL: rdata_d = coreCtl_q;
        ADDR_SUP_CTL:  rdata_d = supCtl_q;
        // Bit 12 mirrors the synchronised wake level
        ADDR_STATUS:   rdata_d = {3'h0, pinWakeQ[1], chan_q, mask_q, puc_q, supFlag_q, coreFlag_q};
        default:       rdata_d = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      coreCtl_q  <= CORE_CTL_RST;
      supCtl_q   <= SUP_CTL_RST;
      pmode_q    <= PM_ACTIVE;
      chan_q     <= '{CSSC_NORMAL, CSSC_NORMAL, CSSC_OFF, CSSC_OFF};
      coreCnt_q  <= '0;
      supCnt_q   <= '0;
      maskCnt_q  <= '0;
      coreFlag_q <= 1'b0;
      supFlag_q  <= 1'b0;
      mask_q     <= 1'b0;
      puc_q      <= 1'b0;
      rdata_q    <= 16'h0000;
    end else begin
      coreCtl_q  <= coreCtl_d;
      supCtl_q   <= supCtl_d;
      pmode_q    <= pmode_d;
      chan_q     <= chan_d;
      coreCnt_q  <= coreCnt_d;
      supCnt_q   <= supCnt_d;
      maskCnt_q  <= maskCnt_d;
      coreFlag_q <= coreFlag_d;
      supFlag_q  <= supFlag_d;
      mask_q     <= mask_d;
      puc_q      <= puc_d;
      rdata_q    <= rdata_d;
    end
  end

  assign rdata                = rdata_q;
  assign chanState            = chan_q;
  assign cpuExecMask          = mask_q;
  assign coreSideSettleFlag   = coreFlag_q;
  assign supplySideSettleFlag = supFlag_q;
  assign powerUpClear         = puc_q;

  property p_core_off_disabled;
    @(posedge clk) disable iff (!rstn)
    (coreWr && !bus.wdata[B_SVE]) |=> (chan_q.coreSup == CSSC_OFF);
  endproperty
  a_core_off_disabled: assert property (p_core_off_disabled) else $error("core supervisor not off");

  property p_settle_set;
    @(posedge clk) disable iff (!rstn)
    coreWr |=> coreFlag_q;
  endproperty
  a_settle_set: assert property (p_settle_set) else $error("settle flag not set");

  property p_fast_settle;
    @(posedge clk) disable iff (!rstn)
    (coreWr && bus.wdata[B_SVFP]) ##1 (!coreWr)[*8] |-> ##[1:200] !coreFlag_q;
  endproperty
  a_fast_settle: assert property (p_fast_settle) else $error("fast settle too long");

  property p_slow_settle;
    @(posedge clk) disable iff (!rstn)
    (coreWr && !bus.wdata[B_SVFP]) |=> coreFlag_q[*8];
  endproperty
  a_slow_settle: assert property (p_slow_settle) else $error("slow settle too short");

  property p_mask_on_wake;
    @(posedge clk) disable iff (!rstn)
    deepWake |=> mask_q;
  endproperty
  a_mask_on_wake: assert property (p_mask_on_wake) else $error("mask missing after wake");

  property p_mask_fast;
    @(posedge clk) disable iff (!rstn)
    (deepWake && fastWake) |-> ##[1:201] !mask_q;
  endproperty
  a_mask_fast: assert property (p_mask_fast) else $error("fast mask too long");

  property p_recompute;
    @(posedge clk) disable iff (!rstn)
    (supWr && bus.wdata[B_MNE] && bus.wdata[B_MNFP] && pmNow == PM_ACTIVE && !pmChange)
      |=> (chan_q.supMon == CSSC_FULL);
  endproperty
  a_recompute: assert property (p_recompute) else $error("supply monitor not recomputed");

  property p_ovp;
    @(posedge clk) disable iff (!rstn)
    (supCtl_q[B_OVP] && supCtl_q[B_MNE] && pinOvQ[1]) |=> powerUpClear;
  endproperty
  a_ovp: assert property (p_ovp) else $error("overvoltage reset missing");
endmodule
`default_nettype wire

// ### verif/cssc_mode_control_test.sv
`timescale 1ns/100ps
`default_nettype none
module cssc_mode_control_test;
  import cssc_pkg::*;
  localparam int unsigned SLOW = 40;
  localparam int unsigned FAST = 10;
  logic        clk               = 1'b0;
  logic        rstn              = 1'b0;
  cssc_bus_s   bus               = '0;
  logic        lowPowerMode2     = 1'b0;
  logic        lowPowerMode34    = 1'b0;
  logic        coreVoltageLow    = 1'b0;
  logic        supplyOverVoltage = 1'b0;
  logic        wakeUp;
  logic [15:0] rdata;
  cssc_chan_s  chan;
  logic        mask;
  logic        coreFlag;
  logic        supFlag;
  logic        power_up_clear;
  int          err_total         = 0;
  int          samples_checked   = 0;

  always #5 clk = ~clk;
  assign wakeUp = ~(lowPowerMode2 | lowPowerMode34);

  cssc_mode_control #(.SLOW_CYCLES(SLOW), .FAST_CYCLES(FAST)) u_dut (
    .clk(clk), .rstn(rstn), .bus(bus), .rdata(rdata),
    .lowPowerMode2(lowPowerMode2), .lowPowerMode34(lowPowerMode34), .wakeUp(wakeUp),
    .coreVoltageLow(coreVoltageLow), .supplyOverVoltage(supplyOverVoltage),
    .chanState(chan), .cpuExecMask(mask), .coreSideSettleFlag(coreFlag),
    .supplySideSettleFlag(supFlag), .powerUpClear(power_up_clear)
  );

  task automatic close_out;
    if (err_total == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task automatic step;
    @(posedge clk);
    #1;
  endtask

  task automatic wr(input logic [1:0] a, input logic [15:0] d);
    @(posedge clk);
    bus <= '{write: 1'b1, read: 1'b0, addr: a, wdata: d};
    @(posedge clk);
    bus <= '0;
    #1;
  endtask

  task automatic rd(input logic [1:0] a, output logic [15:0] d);
    @(posedge clk);
    bus <= '{write: 1'b0, read: 1'b1, addr: a, wdata: 16'h0000};
    @(posedge clk);
    bus <= '0;
    #1 d = rdata;
  endtask

  task automatic do_reset;
    @(posedge clk);
    rstn <= 1'b0;
    coreVoltageLow <= 1'b0;
    supplyOverVoltage <= 1'b0;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
  endtask

  function automatic logic sig(input int s);
    case (s)
      0: return coreFlag | supFlag;
      1: return mask;
      default: return power_up_clear;
    endcase
  endfunction

  // Bounded wait, returns cycles spent
  task automatic wait_for(input int s, input logic lvl, input int lim, output int n);
    for (n = 0; n < lim && sig(s) !== lvl; n++) step();
    if (n == lim) begin
      err_total++;
      $display("MISMATCH %0t wait %0d ran out", $time, s);
      close_out();
    end
  endtask

  function automatic logic [15:0] exp_st(input logic en, lp, fp, au, dp);
    if (!en || (dp && !lp)) return 16'(CSSC_OFF);
    if (!dp || !au) return fp ? 16'(CSSC_FULL) : 16'(CSSC_NORMAL);
    return fp ? 16'(CSSC_NORMAL) : 16'(CSSC_OFF);
  endfunction

  // Every combination of control bits 0 to 5, active then deep
  task automatic table_run(input logic [1:0] a);
    logic [15:0] s;
    logic [15:0] m;
    int          n;
    for (int v = 0; v < 64; v++) begin
      wr(a, 16'(v));
      wait_for(0, 1'b0, 200, n);
      for (int d = 0; d < 2; d++) begin
        repeat (4) step();
        s = 16'((a == 2'h0) ? chan.coreSup : chan.supSup);
        m = 16'((a == 2'h0) ? chan.coreMon : chan.supMon);
        chk(s, exp_st(v[0], v[1], v[2], v[5], d[0]), "supervisor");
        chk(m, exp_st(v[3], 1'b1, v[4], v[5], d[0]), "monitor");
        @(posedge clk);
        lowPowerMode2 <= ~d[0] & v[0];
        lowPowerMode34 <= ~d[0] & ~v[0];
      end
      // Next write lands in settled active mode
      repeat (3) step();
    end
  endtask

  task automatic settle_run(input logic [1:0] a, input logic [15:0] d, input int exp);
    int n;
    wr(a, d);
    step();
    chk(16'((a == 2'h0) ? coreFlag : supFlag), 16'h0001, "flag set");
    wait_for(0, 1'b0, 2 * SLOW, n);
    chk(16'(n), 16'(exp - 1), "settle length");
  endtask

  task automatic mask_run(input logic [15:0] d, input int exp);
    int n;
    wr(2'h0, d);
    wait_for(0, 1'b0, 200, n);
    wait_for(1, 1'b0, 2 * SLOW, n);
    @(posedge clk);
    lowPowerMode34 <= 1'b1;
    repeat (6) step();
    @(posedge clk);
    lowPowerMode34 <= 1'b0;
    wait_for(1, 1'b1, 8, n);
    wait_for(1, 1'b0, 2 * SLOW, n);
    chk(16'(n), 16'(exp), "mask length");
  endtask

  task automatic puc_run;
    int n;
    do_reset();
    @(posedge clk);
    coreVoltageLow <= 1'b1;
    wr(2'h0, 16'h0001);
    wait_for(2, 1'b1, 2 * SLOW, n);
    chk(16'(n), 16'(SLOW), "reset at expiry");
    do_reset();
    @(posedge clk);
    supplyOverVoltage <= 1'b1;
    repeat (4) step();
    chk(16'(power_up_clear), 16'h0000, "no protect reset");
    wr(2'h1, 16'h0048);
    wait_for(2, 1'b1, 10, n);
    do_reset();
  endtask

  initial begin
    logic [15:0] d;
    do_reset();
    step();
    chk(16'(chan), 16'h0050, "reset states");
    rd(2'h0, d);
    chk(d, CORE_CTL_RST, "core ctl reset");
    rd(2'h1, d);
    chk(d, SUP_CTL_RST, "supply ctl reset");
    wr(2'h3, 16'hFFFF);
    rd(2'h3, d);
    chk(d, 16'h0000, "unmapped read");
    wr(2'h2, 16'hFFFF);
    rd(2'h2, d);
    chk(d, 16'h1500, "status reset");
    table_run(2'h0);
    table_run(2'h1);
    settle_run(2'h0, 16'h0005, FAST);
    settle_run(2'h0, 16'h0001, SLOW);
    settle_run(2'h1, 16'h0005, FAST);
    settle_run(2'h1, 16'h0001, SLOW);
    mask_run(16'h0009, SLOW);
    mask_run(16'h0000, FAST);
    mask_run(16'h001D, FAST);
    puc_run();
    close_out();
  end
endmodule
`default_nettype wire
